/* File: src/ocs_defs.svh */
// offsets, field positions, reset values and timing figures of the oscillator control block
`ifndef OCS_DEFS_SVH
`define OCS_DEFS_SVH

`define OCS_ADDR_CTRL      8'h00
`define OCS_ADDR_TRIM      8'h01
`define OCS_SEL_LSB        4
`define OCS_SEL_MSB        6
`define OCS_EXT_BIT        3
`define OCS_FAST_OK_BIT    2
`define OCS_SLOW_OK_BIT    1
`define OCS_SCS_BIT        0
`define OCS_TRIM_MSB       4
`define OCS_SEL_RESET      3'h6
`define OCS_SEL_SLOW       3'h0
`define OCS_SEL_FAST_MAX   3'h7
`define OCS_TRIM_RESET     5'h00
`define OCS_DIVIDED_CLOCK_OUT_DIV     4
`define OCS_FAST_HZ        8000000
`define OCS_SLOW_HZ        31000
`define OCS_SYS_HZ         25000000
`define OCS_STARTUP_NS     2000
`define OCS_FAST_HALF      (`OCS_SYS_HZ / `OCS_FAST_HZ / 2)
`define OCS_SLOW_HALF      (`OCS_SYS_HZ / `OCS_SLOW_HZ / 2)
`define OCS_STARTUP_CYC    ((`OCS_STARTUP_NS * 25 + 999) / 1000)

`endif

/* File: src/ocs_pkg.sv */
// types shared by the oscillator control block
package ocs_pkg;

	typedef enum logic [1:0]
	{
		ocs_src_external,
		ocs_src_fast,
		ocs_src_slow
	} ocs_src_type;

	typedef enum logic [2:0]
	{
		ocs_sw_idle,
		ocs_sw_startup,
		ocs_sw_wait_fall,
		ocs_sw_wait_rise
	} ocs_sw_type;

	typedef struct packed
	{
		logic addr_unused;
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} ocs_bus_type;

	typedef struct packed
	{
		logic [2:0] osc_mode;
		logic       two_speed_enable;
		logic       power_up_delay_timer;
		logic       watchdog_timer;
		logic       clock_fail_monitor;
	} ocs_cfg_type;

endpackage : ocs_pkg

/* File: src/ocs_top.sv */
// oscillator control: pin modes, internal oscillator selection, trim and clock switching
//
// Contract
// - RC mode with clock output: output pin carries RC clock divided by four.
// - RC mode without clock output: output pin becomes general purpose I/O.
// - internal mode with output: input pin is I/O, output pin internal clock/4.
// - internal mode without output: both oscillator pins are general purpose I/O.
// - fast oscillator at 8 MHz feeds postscaler giving seven selectable frequencies.
// - fast oscillator on when select nonzero and clock select or two-speed set.
// - readable status bit shows fast oscillator stable.
// - trim is 5-bit two's complement, zero after reset.
// - trim 01111 max, 00000 calibrated, 10000 min, monotonic between.
// - trim change moves frequency gradually, no completion flag.
// - trim never affects slow oscillator or its timers.
// - slow oscillator runs 31 kHz, time base for timers and fail monitor.
// - slow oscillator on for select 000 with clock select, two-speed, or timers.
// - readable status bit shows slow oscillator stable.
// - reset loads frequency select with 110, 4 MHz.
// - switch: startup delay if off, wait old fall, hold low, new rise, connect. Code delays every fast/slow move, even if the new oscillator already runs.
// - no startup delay among fast oscillator selections.
// - clock select 0 uses configured mode, 1 uses selected internal frequency.
// - every reset clears the clock select bit.
// - automatic source changes leave clock select; external-active bit shows actual source.
// - select codes 111 8 MHz down to 001 125 kHz, 000 slow oscillator.
// - external-active bit reads 1 on external clock, 0 on internal.
`include "ocs_defs.svh"

module ocs_top #(
	parameter int STARTUP_CYC = `OCS_STARTUP_CYC,
	parameter int FAST_HALF   = `OCS_FAST_HALF,
	parameter int SLOW_HALF   = `OCS_SLOW_HALF
)(
	input  wire logic                 clk_i,
	input  wire logic                 rstn_i,
	input  wire ocs_pkg::ocs_bus_type bus_i,
	output logic [7:0]                rdata_o,
	input  wire ocs_pkg::ocs_cfg_type cfg_i,
	input  wire logic                 auto_internal_i,
	input  wire logic                 rc_clock_i,
	input  wire logic                 ext_clock_i,
	output logic                      osc_input_pin_oe_o,
	output logic                      osc_output_pin_o,
	output logic                      osc_output_pin_oe_o,
	output logic                      osc_input_pin_gpio_o,
	output logic                      osc_output_pin_gpio_o,
	output logic                      sys_clock_o,
	output logic [4:0]                trim_value_o,
	output logic                      slow_internal_osc_en_o,
	output logic                      fast_internal_osc_en_o
);

	// ---------------------------------------------------------------
	// parameter checks
	// ---------------------------------------------------------------
	initial
		if (STARTUP_CYC < 1 || FAST_HALF < 1 || SLOW_HALF < 1)
			$error("ocs_top: counts must be at least one");

	localparam logic [2:0] MODE_RC_OUT  = 3'h3;
	localparam logic [2:0] MODE_RC_IO   = 3'h2;
	localparam logic [2:0] MODE_INT_OUT = 3'h5;
	localparam logic [2:0] MODE_INT_IO  = 3'h4;

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	logic [2:0] internal_freq_select;
	logic       system_clock_select;
	logic [4:0] trim_value;
	logic       fast_osc_stable;
	logic       slow_osc_stable;
	logic       external_clock_active;

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			internal_freq_select <= `OCS_SEL_RESET;
			system_clock_select  <= 1'b0;
		end
		else if (bus_i.wr && bus_i.addr == `OCS_ADDR_CTRL)
		begin
			internal_freq_select <= bus_i.wdata[`OCS_SEL_MSB:`OCS_SEL_LSB];
			system_clock_select  <= bus_i.wdata[`OCS_SCS_BIT];
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			trim_value <= `OCS_TRIM_RESET;
		else if (bus_i.wr && bus_i.addr == `OCS_ADDR_TRIM)
			trim_value <= bus_i.wdata[`OCS_TRIM_MSB:0];
	end

	// trim passes out to the analogue core only; slow path never sees it
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			trim_value_o <= `OCS_TRIM_RESET;
		else
			trim_value_o <= trim_value;
	end

	// ---------------------------------------------------------------
	// oscillator enables
	// ---------------------------------------------------------------
	logic sel_slow;
	logic fast_en;
	logic slow_en;
	assign sel_slow = (internal_freq_select == `OCS_SEL_SLOW);
	assign fast_en  = !sel_slow && (system_clock_select || cfg_i.two_speed_enable);
	assign slow_en  = (sel_slow && (system_clock_select || cfg_i.two_speed_enable))
	                || cfg_i.power_up_delay_timer || cfg_i.watchdog_timer
	                || cfg_i.clock_fail_monitor;

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			fast_internal_osc_en_o <= 1'b0;
			slow_internal_osc_en_o <= 1'b0;
		end
		else
		begin
			fast_internal_osc_en_o <= fast_en;
			slow_internal_osc_en_o <= slow_en;
		end
	end

	// ---------------------------------------------------------------
	// oscillator models: fast with postscaler, slow untrimmed
	// ---------------------------------------------------------------
	logic [15:0] fast_cnt;
	logic        fast_base;
	logic [6:0]  post;
	logic [15:0] slow_cnt;
	logic        slow_clk;
	ocs_pkg::ocs_sw_type sw_state;

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			fast_cnt  <= 16'h0000;
			fast_base <= 1'b0;
			post      <= 7'h00;
		end
		else if (!fast_en && sw_state == ocs_pkg::ocs_sw_idle)   // runs on through a switch
		begin
			fast_cnt  <= 16'h0000;
			fast_base <= 1'b0;
		end
		else if (fast_cnt >= 16'(FAST_HALF - 1))
		begin
			fast_cnt  <= 16'h0000;
			fast_base <= !fast_base;
			if (fast_base)
				post <= post + 7'h01;
		end
		else
			fast_cnt <= fast_cnt + 16'h0001;
	end

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			slow_cnt <= 16'h0000;
			slow_clk <= 1'b0;
		end
		else if (!slow_en && sw_state == ocs_pkg::ocs_sw_idle)   // runs on through a switch
		begin
			slow_cnt <= 16'h0000;
			slow_clk <= 1'b0;
		end
		else if (slow_cnt >= 16'(SLOW_HALF - 1))
		begin
			slow_cnt <= 16'h0000;
			slow_clk <= !slow_clk;
		end
		else
			slow_cnt <= slow_cnt + 16'h0001;
	end

	// selected internal frequency: 7 -> base, 6 -> /2 ... 1 -> /64, 0 -> slow
	function automatic logic pick(input logic [2:0] s, input logic b, input logic [6:0] p, input logic sl);
		logic r;
		r = sl;
		if (s == `OCS_SEL_FAST_MAX)
			r = b;
		else if (s != `OCS_SEL_SLOW)
			r = p[3'(`OCS_SEL_FAST_MAX - s - 3'h1)];
		return r;
	endfunction

	// ---------------------------------------------------------------
	// glitch-free switch between internal selections
	// ---------------------------------------------------------------
	logic [2:0]  active_sel;
	logic [2:0]  target_sel;
	logic [15:0] start_cnt;
	logic        int_clk;
	logic        old_clk;
	logic        new_clk;
	logic        int_clk_q;
	logic        new_clk_q;
	assign old_clk = pick(active_sel, fast_base, post, slow_clk);
	assign new_clk = pick(target_sel, fast_base, post, slow_clk);

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			int_clk_q <= 1'b0;
			new_clk_q <= 1'b0;
		end
		else
		begin
			int_clk_q <= old_clk;
			new_clk_q <= new_clk;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			sw_state   <= ocs_pkg::ocs_sw_idle;
			active_sel <= `OCS_SEL_RESET;
			target_sel <= `OCS_SEL_RESET;
			start_cnt  <= 16'h0000;
			int_clk    <= 1'b0;
		end
		else
		begin
			unique case (sw_state)
				ocs_pkg::ocs_sw_idle:
				begin
					int_clk <= old_clk;
					if (internal_freq_select != active_sel)
					begin
						target_sel <= internal_freq_select;
						start_cnt  <= 16'(STARTUP_CYC);
						// same-oscillator moves skip the startup delay
						if ((internal_freq_select == `OCS_SEL_SLOW) == (active_sel == `OCS_SEL_SLOW))
							sw_state <= ocs_pkg::ocs_sw_wait_fall;
						else
							sw_state <= ocs_pkg::ocs_sw_startup;
					end
				end
				ocs_pkg::ocs_sw_startup:
				begin
					int_clk <= old_clk;
					if (start_cnt <= 16'h0001)
						sw_state <= ocs_pkg::ocs_sw_wait_fall;
					else
						start_cnt <= start_cnt - 16'h0001;
				end
				ocs_pkg::ocs_sw_wait_fall:
				begin
					int_clk <= old_clk;
					if (int_clk_q && !old_clk)
					begin
						int_clk  <= 1'b0;
						sw_state <= ocs_pkg::ocs_sw_wait_rise;
					end
				end
				ocs_pkg::ocs_sw_wait_rise:
				begin
					int_clk <= 1'b0;
					if (!new_clk_q && new_clk)
					begin
						int_clk    <= 1'b1;
						active_sel <= target_sel;
						sw_state   <= ocs_pkg::ocs_sw_idle;
					end
				end
				default:
					sw_state <= ocs_pkg::ocs_sw_idle;
			endcase
		end
	end

	// stable flags follow the connected oscillator and enables
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			fast_osc_stable <= 1'b0;
			slow_osc_stable <= 1'b0;
		end
		else if (sw_state == ocs_pkg::ocs_sw_idle && internal_freq_select == active_sel)
		begin
			fast_osc_stable <= fast_en && active_sel != `OCS_SEL_SLOW;
			slow_osc_stable <= slow_en;
		end
	end

	// ---------------------------------------------------------------
	// system clock source and pins
	// ---------------------------------------------------------------
	logic use_ext;
	logic int_mode;
	logic [1:0] div4;
	logic ref_q;
	logic ref_clk;
	assign int_mode = (cfg_i.osc_mode == MODE_INT_OUT) || (cfg_i.osc_mode == MODE_INT_IO);
	assign use_ext  = !system_clock_select && !auto_internal_i && !int_mode;
	assign ref_clk  = (cfg_i.osc_mode == MODE_RC_OUT) ? rc_clock_i : int_clk;

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			external_clock_active <= 1'b0;
			sys_clock_o           <= 1'b0;
		end
		else
		begin
			external_clock_active <= use_ext;
			sys_clock_o           <= use_ext ? (cfg_i.osc_mode[2:1] == MODE_RC_IO[2:1] ? rc_clock_i : ext_clock_i) : int_clk;
		end
	end

	// divide by four on rising edges of the reference
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			ref_q <= 1'b0;
			div4  <= 2'h0;
		end
		else
		begin
			ref_q <= ref_clk;
			if (ref_clk && !ref_q)
				div4 <= div4 + 2'h1;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			osc_output_pin_o      <= 1'b0;
			osc_output_pin_oe_o   <= 1'b0;
			osc_input_pin_oe_o    <= 1'b0;
			osc_input_pin_gpio_o  <= 1'b0;
			osc_output_pin_gpio_o <= 1'b0;
		end
		else
		begin
			osc_output_pin_o      <= div4[1] && ((cfg_i.osc_mode == MODE_RC_OUT) || (cfg_i.osc_mode == MODE_INT_OUT));
			osc_output_pin_oe_o   <= (cfg_i.osc_mode == MODE_RC_OUT) || (cfg_i.osc_mode == MODE_INT_OUT);
			osc_input_pin_oe_o    <= 1'b0;
			osc_input_pin_gpio_o  <= int_mode;
			osc_output_pin_gpio_o <= (cfg_i.osc_mode == MODE_RC_IO) || (cfg_i.osc_mode == MODE_INT_IO);
		end
	end

	// ---------------------------------------------------------------
	// register read port
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			rdata_o <= 8'h00;
		else if (bus_i.rd && bus_i.addr == `OCS_ADDR_CTRL)
			rdata_o <= {1'b0, internal_freq_select, external_clock_active,
			            fast_osc_stable, slow_osc_stable, system_clock_select};
		else if (bus_i.rd && bus_i.addr == `OCS_ADDR_TRIM)
			rdata_o <= {3'h0, trim_value};
		else
			rdata_o <= 8'h00;
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	chk_reset_select: assert property (@(posedge clk_i) $rose(rstn_i) |-> internal_freq_select == `OCS_SEL_RESET && !system_clock_select)
		else $error("select or clock select wrong after reset");
	chk_fast_enable: assert property (@(posedge clk_i) disable iff (!rstn_i) fast_internal_osc_en_o == $past(fast_en))
		else $error("fast enable mismatch");
	chk_switch_low: assert property (@(posedge clk_i) disable iff (!rstn_i) sw_state == ocs_pkg::ocs_sw_wait_rise |=> !int_clk || sw_state == ocs_pkg::ocs_sw_idle)
		else $error("clock not held low during switch");
	chk_ext_flag: assert property (@(posedge clk_i) disable iff (!rstn_i) system_clock_select |=> !external_clock_active)
		else $error("external flag set on internal clock");
	sequence seq_old_fall;
		sw_state == ocs_pkg::ocs_sw_wait_fall && int_clk_q && !old_clk;
	endsequence
	chk_hold_after_fall: assert property (@(posedge clk_i) disable iff (!rstn_i)
		seq_old_fall |=> !int_clk && sw_state == ocs_pkg::ocs_sw_wait_rise)
		else $error("clock not parked low after old clock fell");
	chk_pin_released: assert property (@(posedge clk_i) disable iff (!rstn_i)
		cfg_i.osc_mode == MODE_RC_IO |=> osc_output_pin_gpio_o && !osc_output_pin_oe_o)
		else $error("output pin not released in rc mode without clock output");

endmodule // ocs_top

/* File: verif/tb.sv */
// self-checking testbench of the oscillator control block
module tb;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------
	// stimulus and observed signals
	// ----------------------------------------
	logic                 clk_i;
	logic                 rstn_i;
	ocs_pkg::ocs_bus_type bus;
	ocs_pkg::ocs_cfg_type cfg;
	logic                 auto_int;
	logic                 rc_clk;
	logic                 ext_clk;
	logic [7:0]           rdata;
	logic                 in_oe;
	logic                 out_pin;
	logic                 out_oe;
	logic                 in_gpio;
	logic                 out_gpio;
	logic                 sys_clk;
	logic [4:0]           trim;
	logic                 slow_en;
	logic                 fast_en;
	logic [7:0]           phase;
	int                   bad_count;
	int                   n_compared;

	ocs_top #(.STARTUP_CYC(10), .FAST_HALF(2), .SLOW_HALF(8)) dut (
		.clk_i                  (clk_i),
		.rstn_i                 (rstn_i),
		.bus_i                  (bus),
		.rdata_o                (rdata),
		.cfg_i                  (cfg),
		.auto_internal_i        (auto_int),
		.rc_clock_i             (rc_clk),
		.ext_clock_i            (ext_clk),
		.osc_input_pin_oe_o     (in_oe),
		.osc_output_pin_o       (out_pin),
		.osc_output_pin_oe_o    (out_oe),
		.osc_input_pin_gpio_o   (in_gpio),
		.osc_output_pin_gpio_o  (out_gpio),
		.sys_clock_o            (sys_clk),
		.trim_value_o           (trim),
		.slow_internal_osc_en_o (slow_en),
		.fast_internal_osc_en_o (fast_en)
	);

	// ----------------------------------------
	// clock, rc and external clock sources
	// ----------------------------------------
	always #20 clk_i = ~clk_i;

	// rc clock has a period of four system clocks
	always @(posedge clk_i)
	begin
		phase   <= phase + 8'h01;
		rc_clk  <= phase[1];
		ext_clk <= phase[2];
	end

	// ----------------------------------------
	// bus cycles and comparison
	// ----------------------------------------
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] addr, input logic [7:0] data);
		@(posedge clk_i);
		bus.addr  <= addr;
		bus.wdata <= data;
		bus.wr    <= 1'b1;
		@(posedge clk_i);
		bus.wr    <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] addr, output logic [7:0] data);
		@(posedge clk_i);
		bus.addr <= addr;
		bus.rd   <= 1'b1;
		@(posedge clk_i);
		bus.rd   <= 1'b0;
		// data stand for this one cycle; taken before the closing edge updates them
		@(posedge clk_i);
		data = rdata;
	endtask

	// polls the control register until a bit takes a value
	task automatic wait_bit(input int bitn, input logic val);
		logic [7:0] v;
		int         n;
		n = 0;
		rd(8'h00, v);
		while (v[bitn] !== val && n < 300)
		begin
			rd(8'h00, v);
			n++;
		end
		check("status bit", {7'h00, v[bitn]}, {7'h00, val});
	endtask

	task automatic count_rises(input logic which, output int n);
		logic prev;
		logic cur;
		n    = 0;
		prev = which ? sys_clk : out_pin;
		repeat (128)
		begin
			@(posedge clk_i);
			cur = which ? sys_clk : out_pin;
			if (cur === 1'b1 && prev === 1'b0)
				n++;
			prev = cur;
		end
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset;
		logic [7:0] v;
		rd(8'h00, v);
		check("control after reset", v & 8'h71, 8'h60);
		rd(8'h01, v);
		check("trim after reset", v, 8'h00);
		check("trim output after reset", {3'h0, trim}, 8'h00);
		$display("test reset done");
	endtask

	task automatic t_trim;
		logic [7:0] v;
		logic [7:0] vals[5];
		vals = '{8'h0F, 8'h00, 8'h10, 8'h1F, 8'hEF};
		foreach (vals[i])
		begin
			wr(8'h01, vals[i]);
			rd(8'h01, v);
			check("trim readback", v, vals[i] & 8'h1F);
			check("trim output", {3'h0, trim}, vals[i] & 8'h1F);
		end
		rd(8'h05, v);
		check("unmapped read", v, 8'h00);
		wr(8'h05, 8'hFF);
		rd(8'h00, v);
		check("control after unmapped write", v & 8'h71, 8'h60);
		wr(8'h00, 8'h6E);
		rd(8'h00, v);
		check("status bits not writable", v, 8'h68);
		$display("test trim done");
	endtask

	task automatic t_select;
		logic [7:0] v;
		for (int s = 7; s >= 0; s--)
		begin
			wr(8'h00, {1'b0, s[2:0], 4'h1});
			wait_bit(3, 1'b0);
			wait_bit(s == 0 ? 1 : 2, 1'b1);
			rd(8'h00, v);
			check("select readback", {5'h00, v[6:4]}, {5'h00, s[2:0]});
			check("fast enable", {7'h00, fast_en}, {7'h00, s != 0});
			check("slow enable", {7'h00, slow_en}, {7'h00, s == 0});
		end
		wr(8'h00, 8'h60);
		wait_bit(3, 1'b1);
		check("fast off on external", {7'h00, fast_en}, 8'h00);
		cfg.two_speed_enable <= 1'b1;
		repeat (3) @(posedge clk_i);
		check("fast on with two-speed", {7'h00, fast_en}, 8'h01);
		wr(8'h00, 8'h00);
		repeat (3) @(posedge clk_i);
		check("slow on with two-speed", {7'h00, slow_en}, 8'h01);
		cfg.two_speed_enable <= 1'b0;
		wr(8'h00, 8'h60);
		cfg.watchdog_timer <= 1'b1;
		repeat (3) @(posedge clk_i);
		check("slow on with watchdog", {7'h00, slow_en}, 8'h01);
		cfg.watchdog_timer <= 1'b0;
		$display("test select done");
	endtask

	task automatic t_auto;
		logic [7:0] v;
		int         n;
		auto_int <= 1'b1;
		wait_bit(3, 1'b0);
		rd(8'h00, v);
		check("clock select kept", {7'h00, v[0]}, 8'h00);
		auto_int <= 1'b0;
		wait_bit(3, 1'b1);
		count_rises(1'b1, n);
		check("system clock from external", {7'h00, n >= 15 && n <= 17}, 8'h01);
		$display("test auto switch done");
	endtask

	task automatic t_pins;
		int n;
		logic [2:0] modes[4];
		modes = '{3'h2, 3'h3, 3'h4, 3'h5};
		// internal oscillator running so the clock output mode has a source
		wr(8'h00, 8'h61);
		foreach (modes[i])
		begin
			cfg.osc_mode <= modes[i];
			repeat (40) @(posedge clk_i);
			count_rises(1'b0, n);
			check("output drive", {7'h00, out_oe}, {7'h00, modes[i][0]});
			check("output gpio", {7'h00, out_gpio}, {7'h00, ~modes[i][0]});
			check("input gpio", {7'h00, in_gpio}, {7'h00, modes[i][2]});
			check("input never driven", {7'h00, in_oe}, 8'h00);
			if (modes[i] == 3'h3)
				check("rc divided by four", {7'h00, n >= 7 && n <= 9}, 8'h01);
			else if (modes[i] == 3'h5)
				check("internal clock out", {7'h00, n >= 3 && n <= 5}, 8'h01);
			else
				check("output quiet", n[7:0], 8'h00);
		end
		cfg.osc_mode <= 3'h0;
		$display("test pins done");
	endtask

	task automatic t_reset_mid;
		logic [7:0] v;
		wr(8'h00, 8'h71);
		wr(8'h01, 8'h0A);
		@(posedge clk_i);
		rstn_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rstn_i <= 1'b1;
		rd(8'h00, v);
		check("control after second reset", v & 8'h71, 8'h60);
		rd(8'h01, v);
		check("trim after second reset", v, 8'h00);
		$display("test second reset done");
	endtask

	// ----------------------------------------
	// run control
	// ----------------------------------------
	task automatic complete_run;
		$display("comparisons %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial
	begin
		#2400000;
		bad_count++;
		complete_run();
	end

	initial
	begin
		clk_i      = 1'b0;
		rstn_i     = 1'b0;
		bus        = '0;
		cfg        = '0;
		auto_int   = 1'b0;
		rc_clk     = 1'b0;
		ext_clk    = 1'b0;
		phase      = 8'h00;
		bad_count  = 0;
		n_compared = 0;
		repeat (5) @(posedge clk_i);
		rstn_i <= 1'b1;
		t_reset();
		t_trim();
		t_select();
		t_auto();
		t_pins();
		t_reset_mid();
		complete_run();
	end
endmodule // tb
